// *** core/qsm_pkg.sv ***
// constants, carrier types and shared helpers for the four-line serial mux
// assumes a single 100 MHz system clock and synchronous active-high reset
package qsm_pkg;

  localparam int NUM_LINES   = 4;
  localparam int LINE_W      = 2;
  localparam int DATA_W      = 8;
  localparam int QUEUE_DEPTH = 32;
  localparam int PTR_W       = 5;

  // bit clock is sixteen times the baud rate
  localparam int CLK_HZ      = 100_000_000;
  localparam int BAUD_RATE   = 9600;
  localparam int OVERSAMPLE  = 16;
  localparam int BAUD_DIV    = CLK_HZ / (OVERSAMPLE * BAUD_RATE);

  localparam logic [3:0] LAST_TICK  = 4'hf;
  localparam logic [3:0] MID_TICK   = 4'h7;
  localparam logic [7:0] STOP_ONE   = 8'h10;
  localparam logic [7:0] STOP_TWO   = 8'h20;
  localparam logic [7:0] STOP_ONEHF = 8'h18;
  localparam logic [3:0] MIN_BITS   = 4'h5;

  // scan phases of one strobe
  localparam logic [1:0] PH_CLEAR   = 2'h0;
  localparam logic [1:0] PH_PUSH    = 2'h2;
  localparam logic [1:0] PH_RELEASE = 2'h3;

  typedef struct packed {
    logic parity_disable_select;
    logic stop_count_select;
    logic length_select_high;
    logic length_select_low;
    logic parity_type_select;
  } qsm_frame_cfg_t;

  typedef struct packed {
    logic              framing_error_flag;
    logic              parity_error_flag;
    logic [DATA_W-1:0] data;
  } qsm_rx_word_t;

  typedef struct packed {
    logic              framing_error_flag;
    logic              parity_error_flag;
    logic [LINE_W-1:0] source_line_bits;
    logic [DATA_W-1:0] data;
  } qsm_entry_t;

  function automatic logic [3:0] qsm_data_bits(input qsm_frame_cfg_t c);
    return MIN_BITS + {2'h0, c.length_select_high, c.length_select_low};
  endfunction

  // odd parity when type select is low
  function automatic logic qsm_parity(input logic [DATA_W-1:0] d, input logic even);
    return ^d ^ ~even;
  endfunction

endpackage

// *** core/qsm_line_xcvr.sv ***
// one asynchronous receiver/transmitter line with strapped framing
// assumes tick16_i is a one-cycle pulse at sixteen times the baud rate
`timescale 1ns/1ns
module qsm_line_xcvr (
  // clock and clears
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_i,
  input  wire logic                  power_clear_pulse_i,
  input  wire logic                  tick16_i,
  // framing straps
  input  wire qsm_pkg::qsm_frame_cfg_t cfg_i,
  // transmit side
  input  wire logic                  transmit_load_strobe_n_i,
  input  wire logic [7:0]            tx_data_i,
  output logic                       serial_out_o,
  output logic                       transmit_holding_empty_o,
  // receive side
  input  wire logic                  serial_in_i,
  input  wire logic                  clear_receive_available_i,
  output logic                       receive_available_o,
  output qsm_pkg::qsm_rx_word_t      rx_word_o
);

  logic [3:0]  nbits;
  logic        par_on;
  logic [7:0]  dmask;
  logic [7:0]  tx_dm;
  logic [10:0] tx_frame;
  logic [7:0]  tx_ticks;
  logic [7:0]  rx_dn;
  logic        clr;
  logic        ld_rise;
  logic        ld_prev_reg;
  logic [7:0]  hold_reg;
  logic        hold_full_reg;
  logic        tx_busy_reg;
  logic [10:0] tx_sh_reg;
  logic [7:0]  tx_left_reg;
  logic [3:0]  tx_tick_reg;
  logic        rx_busy_reg;
  logic [3:0]  rx_tick_reg;
  logic [3:0]  rx_bit_reg;
  logic [7:0]  rx_sh_reg;
  logic        rx_pbit_reg;

  assign clr      = rst_i | power_clear_pulse_i;
  assign nbits    = qsm_pkg::qsm_data_bits(cfg_i);
  assign par_on   = ~cfg_i.parity_disable_select;
  assign dmask    = 8'hff >> (4'h8 - nbits);
  assign ld_rise  = ld_prev_reg & ~transmit_load_strobe_n_i ? 1'b0 : ~ld_prev_reg & transmit_load_strobe_n_i;
  assign tx_dm    = hold_reg & dmask;
  // start bit, data, optional parity, then marks for the stop bits
  assign tx_frame = (11'h7ff << (nbits + {3'h0, par_on} + 4'h1)) | {2'h0, tx_dm, 1'b0} |
                    (par_on ? (11'({qsm_pkg::qsm_parity(tx_dm, cfg_i.parity_type_select)}) << (nbits + 4'h1))
                            : 11'h000);
  assign tx_ticks = 8'({nbits + {3'h0, par_on} + 4'h1, 4'h0}) +
                    (!cfg_i.stop_count_select ? qsm_pkg::STOP_ONE :
                     (nbits == qsm_pkg::MIN_BITS) ? qsm_pkg::STOP_ONEHF : qsm_pkg::STOP_TWO);
  assign rx_dn    = rx_sh_reg >> (4'h8 - nbits);

  always_ff @(posedge clk_sys_i) begin
    if (clr) begin
      ld_prev_reg <= 1'b1;
      hold_reg <= 8'h00;
      hold_full_reg <= 1'b0;
      tx_busy_reg <= 1'b0;
      tx_sh_reg <= 11'h7ff;
      tx_left_reg <= 8'h00;
      tx_tick_reg <= 4'h0;
      serial_out_o <= 1'b1;
    end else begin
      ld_prev_reg <= transmit_load_strobe_n_i;
      if (!tx_busy_reg && hold_full_reg) begin
        tx_busy_reg <= 1'b1;
        tx_sh_reg <= tx_frame;
        tx_left_reg <= tx_ticks;
        tx_tick_reg <= 4'h0;
        hold_full_reg <= 1'b0;
      end else if (tx_busy_reg && tick16_i) begin
        tx_tick_reg <= tx_tick_reg + 4'h1;
        tx_left_reg <= tx_left_reg - 8'h01;
        if (tx_tick_reg == qsm_pkg::LAST_TICK) begin
          tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
        end
        if (tx_left_reg == 8'h01) begin
          tx_busy_reg <= 1'b0;
        end
      end
      if (ld_rise) begin
        hold_reg <= tx_data_i;
        hold_full_reg <= 1'b1;
      end
      serial_out_o <= tx_busy_reg ? tx_sh_reg[0] : 1'b1;
    end
  end

  assign transmit_holding_empty_o = ~hold_full_reg;

  always_ff @(posedge clk_sys_i) begin
    if (clr) begin
      rx_busy_reg <= 1'b0;
      rx_tick_reg <= 4'h0;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 8'h00;
      rx_pbit_reg <= 1'b0;
      rx_word_o <= '0;
      receive_available_o <= 1'b0;
    end else begin
      if (clear_receive_available_i) begin
        receive_available_o <= 1'b0;
      end
      if (!rx_busy_reg) begin
        if (tick16_i && !serial_in_i) begin
          rx_busy_reg <= 1'b1;
          rx_tick_reg <= 4'h0;
          rx_bit_reg <= 4'h0;
        end
      end else if (tick16_i) begin
        rx_tick_reg <= rx_tick_reg + 4'h1;
        if (rx_tick_reg == qsm_pkg::MID_TICK) begin
          rx_bit_reg <= rx_bit_reg + 4'h1;
          if (rx_bit_reg == 4'h0) begin
            rx_busy_reg <= ~serial_in_i;
          end else if (rx_bit_reg <= nbits) begin
            rx_sh_reg <= {serial_in_i, rx_sh_reg[7:1]};
          end else if (par_on && rx_bit_reg == nbits + 4'h1) begin
            rx_pbit_reg <= serial_in_i;
          end else begin
            rx_busy_reg <= 1'b0;
            rx_word_o.data <= rx_dn;
            rx_word_o.framing_error_flag <= ~serial_in_i;
            rx_word_o.parity_error_flag <= par_on &
              (qsm_pkg::qsm_parity(rx_dn, cfg_i.parity_type_select) != rx_pbit_reg);
            receive_available_o <= 1'b1;
          end
        end
      end
    end
  end

  AST_NO_PARITY_ERR: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    cfg_i.parity_disable_select && $rose(receive_available_o) |-> !rx_word_o.parity_error_flag)
    else $error("parity error reported with parity disabled");

endmodule

// *** core/qsm_serial_mux.sv ***
// four-line serial mux: scanner, receive queue, transmit priority and host io
// assumes host timing pulses and instruction strobes synchronous to clk_sys_i
`timescale 1ns/1ns
module qsm_serial_mux #(
  parameter int BAUD_DIV = qsm_pkg::BAUD_DIV,
  parameter int DEPTH    = qsm_pkg::QUEUE_DEPTH
) (
  // clock and reset
  input  wire logic                            clk_sys_i,
  input  wire logic                            rst_i,
  // system clears
  input  wire logic                            power_clear_pulse_i,
  input  wire logic                            initialize_i,
  // host timing
  input  wire logic                            host_time_pulse_one_i,
  input  wire logic                            host_time_pulse_three_i,
  input  wire logic                            host_time_state_four_i,
  // host instructions and data
  input  wire logic                            write_character_instruction_i,
  input  wire logic                            read_branch_instruction_i,
  input  wire logic                            read_received_instruction_i,
  input  wire logic                            clear_queue_instruction_i,
  input  wire logic [11:0]                     host_data_i,
  input  wire logic [8:0]                      branch_base_i,
  output logic [11:0]                          host_data_o,
  // service status
  output logic                                 transmit_service_flag_o,
  output logic                                 receive_service_flag_o,
  output logic                                 queue_input_ready_o,
  output logic                                 queue_output_ready_o,
  // serial lines
  input  wire qsm_pkg::qsm_frame_cfg_t [3:0]   line_cfg_i,
  input  wire logic [3:0]                      serial_in_i,
  output logic [3:0]                           serial_out_o
);

  localparam int DIV_W = $clog2(BAUD_DIV + 1);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam int PTR_W = $clog2(DEPTH);

  // one shared bit-clock divider; every line runs at the same rate
  logic [DIV_W-1:0] div_reg;
  logic             tick16;

  assign tick16 = (div_reg == DIV_W'(BAUD_DIV - 1));

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || tick16) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + DIV_W'(1);
    end
  end

  // scanner: four phases per strobe, lines in rotation
  logic [1:0] phase_reg;
  logic [1:0] line_reg;
  logic [3:0] scan_strobe;
  logic       scan_first;

  assign scan_strobe = 4'h1 << line_reg;
  assign scan_first  = (phase_reg == qsm_pkg::PH_CLEAR);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      phase_reg <= 2'h0;
      line_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      if (phase_reg == qsm_pkg::PH_RELEASE) begin
        line_reg <= line_reg + 2'h1;
      end
    end
  end

  // per-line transceivers
  logic [3:0]                 holding_empty;
  logic [3:0]                 rx_avail;
  logic [3:0]                 load_strobe_n;
  logic [3:0]                 clear_avail;
  qsm_pkg::qsm_rx_word_t [3:0] rx_word;
  logic [7:0]                 xbuf_data_reg;

  for (genvar g = 0; g < qsm_pkg::NUM_LINES; g++) begin : g_line
    qsm_line_xcvr u_xcvr (
      .clk_sys_i                 (clk_sys_i),
      .rst_i                     (rst_i),
      .power_clear_pulse_i       (power_clear_pulse_i),
      .tick16_i                  (tick16),
      .cfg_i                     (line_cfg_i[g]),
      .transmit_load_strobe_n_i  (load_strobe_n[g]),
      .tx_data_i                 (xbuf_data_reg),
      .serial_out_o              (serial_out_o[g]),
      .transmit_holding_empty_o  (holding_empty[g]),
      .serial_in_i               (serial_in_i[g]),
      .clear_receive_available_i (clear_avail[g]),
      .receive_available_o       (rx_avail[g]),
      .rx_word_o                 (rx_word[g])
    );
  end

  // transmit buffer: character and line at pulse three, line strobe in state four
  logic [1:0] xbuf_line_reg;
  logic       xbuf_pend_reg;
  logic       ts4_prev_reg;
  logic       ts4_end;

  assign ts4_end       = ts4_prev_reg & ~host_time_state_four_i;
  // strobe stays low through state four; the line loads on its trailing edge
  assign load_strobe_n = ~({4{host_time_state_four_i & xbuf_pend_reg}} & (4'h1 << xbuf_line_reg));

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || power_clear_pulse_i) begin
      xbuf_data_reg <= 8'h00;
      xbuf_line_reg <= 2'h0;
      xbuf_pend_reg <= 1'b0;
      ts4_prev_reg <= 1'b0;
    end else begin
      ts4_prev_reg <= host_time_state_four_i;
      if (ts4_end) begin
        xbuf_pend_reg <= 1'b0;
      end
      if (write_character_instruction_i && host_time_pulse_three_i) begin
        xbuf_data_reg <= host_data_i[7:0];
        xbuf_line_reg <= host_data_i[9:8];
        xbuf_pend_reg <= 1'b1;
      end
    end
  end

  // receive queue
  qsm_pkg::qsm_entry_t q_mem [DEPTH];
  logic [PTR_W-1:0]    wr_ptr_reg;
  logic [PTR_W-1:0]    rd_ptr_reg;
  logic [CNT_W-1:0]    count_reg;
  logic                q_full;
  logic                q_empty;
  logic                push;
  logic                pop;
  logic                dev_clear;
  logic                capture_reg;
  logic                q_stored_reg;
  qsm_pkg::qsm_entry_t push_entry;
  qsm_pkg::qsm_entry_t head;

  assign dev_clear  = rst_i | power_clear_pulse_i | initialize_i | clear_queue_instruction_i;
  assign q_full     = (count_reg == CNT_W'(DEPTH));
  assign q_empty    = (count_reg == '0);
  assign push       = capture_reg & (phase_reg == qsm_pkg::PH_PUSH) & ~q_full;
  assign pop        = read_received_instruction_i & ~q_empty;
  assign head       = q_mem[rd_ptr_reg];
  assign push_entry = '{framing_error_flag: rx_word[line_reg].framing_error_flag,
                        parity_error_flag:  rx_word[line_reg].parity_error_flag,
                        source_line_bits:   line_reg,
                        data:               rx_word[line_reg].data};
  // a full queue leaves the character waiting in the line holding register
  assign clear_avail = {4{capture_reg & (phase_reg == qsm_pkg::PH_RELEASE) & q_stored_reg}} & scan_strobe;

  assign queue_input_ready_o    = q_full;
  assign queue_output_ready_o   = ~q_empty;
  assign receive_service_flag_o = ~q_empty;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || scan_first) begin
      capture_reg <= 1'b0;
      q_stored_reg <= 1'b0;
    end else begin
      if (rx_avail[line_reg]) begin
        capture_reg <= 1'b1;
      end
      if (push) begin
        q_stored_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      q_mem[wr_ptr_reg] <= push_entry;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (dev_clear) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + PTR_W'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + PTR_W'(1);
      end
      count_reg <= count_reg + CNT_W'(push) - CNT_W'(pop);
    end
  end

  // transmit side: transmit_flag_a, ready, priority encoder
  logic [3:0] transmit_flag_a_reg;
  logic [3:0] ready_reg;
  logic [3:0] serviced_reg;
  logic [3:0] ready_clear;
  logic [1:0] enc_line;
  logic       encoder_any_active;
  logic       prio_hold_reg;
  logic       transmit_service_flag_report;

  assign encoder_any_active = |ready_reg;
  assign enc_line = ready_reg[3] ? 2'h3 : ready_reg[2] ? 2'h2 : ready_reg[1] ? 2'h1 : 2'h0;
  // receive work takes the branch ahead of transmit
  assign transmit_service_flag_report = read_branch_instruction_i & q_empty & encoder_any_active;
  assign ready_clear = {4{transmit_service_flag_report}} & (4'h1 << enc_line);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || power_clear_pulse_i || initialize_i) begin
      transmit_flag_a_reg <= 4'h0;
      ready_reg <= 4'h0;
      serviced_reg <= 4'h0;
    end else begin
      for (int i = 0; i < qsm_pkg::NUM_LINES; i++) begin
        if (ready_clear[i]) begin
          ready_reg[i] <= 1'b0;
          serviced_reg[i] <= 1'b1;
        end
        if (scan_first && scan_strobe[i]) begin
          if (serviced_reg[i] && !ready_clear[i]) begin
            transmit_flag_a_reg[i] <= 1'b0;
            serviced_reg[i] <= 1'b0;
          end else if (holding_empty[i] && !transmit_flag_a_reg[i]) begin
            transmit_flag_a_reg[i] <= 1'b1;
            ready_reg[i] <= 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || power_clear_pulse_i || initialize_i) begin
      prio_hold_reg <= 1'b0;
      transmit_service_flag_o <= 1'b0;
    end else begin
      prio_hold_reg <= encoder_any_active;
      if (host_time_pulse_one_i) begin
        transmit_service_flag_o <= prio_hold_reg;
      end
    end
  end

  // output multiplexer onto the host data bus
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      host_data_o <= 12'h000;
    end else if (read_branch_instruction_i) begin
      host_data_o <= q_empty ? {branch_base_i, 1'b0, enc_line}
                             : {branch_base_i, 1'b1, head.source_line_bits};
    end else if (read_received_instruction_i) begin
      host_data_o <= head;
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  AST_POWER_CLEAR_MARK: assert property (
    power_clear_pulse_i |=> ##1 (serial_out_o == 4'hf) && (holding_empty == 4'hf))
    else $error("power clear did not force mark and empty");

  AST_ONE_STROBE: assert property ($onehot0(~load_strobe_n))
    else $error("more than one line load strobe active");

  AST_PUSH_PHASE: assert property (push |-> phase_reg == 2'h2 && rx_avail[line_reg])
    else $error("queue push outside third scan phase");

  AST_CAPTURE_CLEAR: assert property ((phase_reg == qsm_pkg::PH_CLEAR) |=> !capture_reg)
    else $error("capture flag not cleared at first phase");

  AST_QUEUE_CLEAR: assert property (clear_queue_instruction_i |=> !queue_output_ready_o)
    else $error("clear instruction left queue entries");

  AST_FULL_FLAG: assert property (
    push && count_reg == CNT_W'(DEPTH - 1) && !pop && !dev_clear |=> queue_input_ready_o)
    else $error("queue full not reported");

  AST_SERVICE_AT_TP1: assert property (
    host_time_pulse_one_i && prio_hold_reg && !power_clear_pulse_i && !initialize_i |=> transmit_service_flag_o)
    else $error("transmit flag missed pulse one");

  // scan may set ready flags meanwhile, so only a dropped flag counts
  AST_RX_FIRST: assert property (
    read_branch_instruction_i && !q_empty && !initialize_i && !power_clear_pulse_i |=>
      host_data_o[2] && (($past(ready_reg) & ~ready_reg) == 4'h0))
    else $error("receive did not take branch precedence");

  AST_FIFO_ORDER: assert property (pop && !read_branch_instruction_i |=> host_data_o == $past(head))
    else $error("queue head not delivered");

  AST_PRIORITY: assert property (transmit_service_flag_report && ready_reg[3] |=> !ready_reg[3] && host_data_o[1:0] == 2'h3)
    else $error("line three not given priority");

  COV_PUSH: cover property (push);
  COV_FULL: cover property (queue_input_ready_o);
  COV_TRANSMIT_SERVICE_FLAG_BRANCH: cover property (transmit_service_flag_report ##1 transmit_service_flag_o);
  COV_WRITE_LINE3: cover property (load_strobe_n == 4'h7);

endmodule

// *** test/qsm_term_model.sv ***
// serial terminal on one line: sends and takes 8-bit, no-parity, one-stop characters
// assumes the bit time matches sixteen ticks of the design's divided clock
`timescale 1ns/1ns
module qsm_term_model #(
  parameter int BIT_NS = 320
) (
  // from and to the design
  input  wire logic       line_from_dut_i,
  output logic            line_to_dut_o,
  // bench side
  input  wire logic       send_i,
  input  wire logic [7:0] send_data_i,
  output logic [7:0]      got_data_o,
  output logic            got_stop_o,
  output logic [7:0]      got_n_o
);
  initial begin
    line_to_dut_o = 1'b1;
    got_data_o = 8'h00;
    got_stop_o = 1'b0;
    got_n_o = 8'h00;
  end
  // start low, data lsb first, stop at mark; the line rests at mark between frames
  always @(posedge send_i) begin
    line_to_dut_o = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      line_to_dut_o = send_data_i[i];
      #(BIT_NS);
    end
    line_to_dut_o = 1'b1;
    #(BIT_NS);
  end
  // mid-bit sampling tolerates the design launching bits on any clock edge
  always @(negedge line_from_dut_i) begin
    #(BIT_NS / 2);
    for (int i = 0; i < 8; i++) begin
      #(BIT_NS);
      got_data_o[i] = line_from_dut_i;
    end
    #(BIT_NS);
    got_stop_o = line_from_dut_i;
    got_n_o = got_n_o + 8'h01;
  end
endmodule

// *** test/qsm_serial_mux_bench.sv ***
// self-checking bench for the four-line serial mux
// assumes one terminal model on line 1 and idle mark on the other serial inputs
`timescale 1ns/1ns
module qsm_serial_mux_bench;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        pwr = 1'b0, init = 1'b0, tp1 = 1'b0, tp3 = 1'b0, ts4 = 1'b0;
  logic        wr = 1'b0, rb = 1'b0, rr = 1'b0, cq = 1'b0, send = 1'b0, to_dut, low_seen = 1'b0;
  logic [11:0] hdi = 12'h000, hdo;
  logic [8:0]  base = 9'h000;
  logic [7:0]  sdata = 8'h00, got_data, got_n, d, n0;
  logic        tsf, rsf, qir, qor, got_stop;
  logic [3:0]  sout;
  logic [31:0] seed = 32'h45;
  logic [19:0] cfg = {4{5'h16}};
  int          n_errors = 0, checks = 0, cycles = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  qsm_serial_mux #(.BAUD_DIV(2), .DEPTH(32)) dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .power_clear_pulse_i(pwr), .initialize_i(init),
    .host_time_pulse_one_i(tp1), .host_time_pulse_three_i(tp3), .host_time_state_four_i(ts4),
    .write_character_instruction_i(wr), .read_branch_instruction_i(rb), .read_received_instruction_i(rr),
    .clear_queue_instruction_i(cq), .host_data_i(hdi), .branch_base_i(base), .host_data_o(hdo),
    .transmit_service_flag_o(tsf), .receive_service_flag_o(rsf), .queue_input_ready_o(qir),
    .queue_output_ready_o(qor), .line_cfg_i(cfg), .serial_in_i({2'b11, to_dut, 1'b1}), .serial_out_o(sout));

  qsm_term_model #(.BIT_NS(320)) term (
    .line_from_dut_i(sout[1]), .line_to_dut_o(to_dut), .send_i(send), .send_data_i(sdata),
    .got_data_o(got_data), .got_stop_o(got_stop), .got_n_o(got_n));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [11:0] exp_entry(input logic [1:0] line, input logic [7:0] ch);
    return {2'b00, line, ch};
  endfunction
  function automatic logic [11:0] exp_branch(input logic [8:0] b, input logic rx, input logic [1:0] line);
    return {b, rx, line};
  endfunction

  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_sys_i);
    s = 1'b1;
    @(negedge clk_sys_i);
    s = 1'b0;
  endtask
  task automatic host_write(input logic [1:0] line, input logic [7:0] ch);
    @(negedge clk_sys_i);
    hdi = {2'h0, line, ch};
    wr = 1'b1;
    tp3 = 1'b1;
    @(negedge clk_sys_i);
    wr = 1'b0;
    tp3 = 1'b0;
    ts4 = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    ts4 = 1'b0;
  endtask
  // one frame plus scan delay, so the model is idle again before the next send
  task automatic term_send(input logic [7:0] ch);
    sdata = ch;
    pulse(send);
    repeat (360) @(negedge clk_sys_i);
  endtask

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles > 25000) begin
      n_errors++;
      wrap_up();
    end
  end
  // a load strobe on a wrong line would start a frame there
  always @(negedge clk_sys_i) if (!rst_i && !pwr && (sout[3:2] !== 2'b11 || sout[0] !== 1'b1)) low_seen = 1'b1;

  initial begin
    repeat (5) @(negedge clk_sys_i);
    rst_i = 1'b0;
    check("serial_out", 12'h00f, {8'h00, sout});
    check("queue flags", 12'h000, {9'h000, rsf, qor, qir});
    $display("test reset done");
    repeat (24) @(negedge clk_sys_i);
    pulse(tp1);
    check("tx service", 12'h001, {11'h000, tsf});
    seed = xs(seed);
    base = seed[8:0];
    // all four holding registers empty, so priority order shows line by line
    for (int g = 3; g >= 0; g--) begin
      pulse(rb);
      check("branch tx", exp_branch(base, 1'b0, g[1:0]), hdo);
    end
    pulse(init);
    check("tx service init", 12'h000, {11'h000, tsf});
    $display("test priority done");
    seed = xs(seed);
    d = seed[7:0];
    n0 = got_n;
    host_write(2'h1, d);
    for (int n = 0; n < 1000 && got_n === n0; n++) @(negedge clk_sys_i);
    check("tx char", {4'h0, d}, {4'h0, got_data});
    check("tx stop", 12'h001, {11'h000, got_stop});
    check("other lines idle", 12'h000, {11'h000, low_seen});
    $display("test transmit done");
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      term_send(seed[7:0]);
      check("rx flag", 12'h003, {10'h000, rsf, qor});
      pulse(rb);
      check("branch rx", exp_branch(base, 1'b1, 2'h1), hdo);
      pulse(rr);
      check("rx entry", exp_entry(2'h1, seed[7:0]), hdo);
      check("rx empty", 12'h000, {10'h000, rsf, qor});
    end
    $display("test receive done");
    term_send(8'hff);
    pulse(cq);
    check("queue cleared", 12'h000, {10'h000, rsf, qor});
    $display("test clear done");
    // 32 characters fill the queue; the 33rd waits in the line holding register
    for (int k = 0; k < 33; k++) begin
      seed = xs(seed);
      if (k == 0) d = seed[7:0];
      term_send(seed[7:0]);
    end
    check("queue full", 12'h007, {9'h000, rsf, qor, qir});
    pulse(rr);
    check("oldest first", exp_entry(2'h1, d), hdo);
    check("queue not full", 12'h006, {9'h000, rsf, qor, qir});
    repeat (20) @(negedge clk_sys_i);
    check("waiting char pushed", 12'h007, {9'h000, rsf, qor, qir});
    $display("test full done");
    host_write(2'h2, 8'h00);
    repeat (100) @(negedge clk_sys_i);
    pulse(pwr);
    @(negedge clk_sys_i);
    check("serial_out power", 12'h00f, {8'h00, sout});
    $display("test power clear done");
    wrap_up();
  end
endmodule
